/* hdl/sid_dispatch.sv */
// interrupt enable, vector and return handling of the script interpreter
`timescale 1ns/1ps
module sid_dispatch #(
   parameter int  NUM_IRQ = 16,
   parameter int  PC_W    = 32,
   parameter int  XREG_W  = 32,
   parameter int  NUM_X   = 2,
   parameter int  FLAG_W  = 8
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     direct_mode,
   input  wire logic                     byte_valid,
   input  wire logic [7:0]               byte_data,
   input  wire logic [7:0]               module_addr,
   input  wire logic [NUM_IRQ-1:0]       irq_src,
   input  wire logic [PC_W-1:0]          cur_pc,
   input  wire logic [XREG_W-1:0]        cur_accu,
   input  wire logic [NUM_X*XREG_W-1:0]  cur_xregs,
   input  wire logic [FLAG_W-1:0]        cur_flags,
   input  wire logic                     instr_boundary,
   output logic                          reply_valid,
   output logic [7:0]                    reply_status,
   output logic [7:0]                    reply_instr,
   output logic [NUM_IRQ-1:0]            irq_mask,
   output logic                          irq_global_en,
   output logic                          in_handler,
   output logic                          pc_load,
   output logic [PC_W-1:0]               pc_load_value,
   output logic                          regs_restore,
   output logic [XREG_W-1:0]             restore_accu,
   output logic [NUM_X*XREG_W-1:0]       restore_xregs,
   output logic [FLAG_W-1:0]             restore_flags
);
   // ==========================================================
   // overview
   // sits beside the interpreter core and sees every command frame
   // acts on enable, disable, vector and return instructions only
   // context copied at handler entry, handed back on the return
   // the core must apply pc_load_value and restore_* on the pulse cycle
   // one handler level only: no nesting, no preemption
   // lowest source number wins when several are ready
   // a source without a stored vector is never taken
   // reset clears enables, vector valid bits and pending events
   // instr_boundary comes from the core's own clock: no synchroniser
   // frames may arrive back to back: the receiver needs no gap
   // timing from the edge that takes the last frame byte
   //   +1 frame strobe inside the receiver
   //   +2 reply pulse; mask, global and vectors updated inside
   //   +3 irq_mask and irq_global_en outputs follow
   // take: pc_load and in_handler one edge after the boundary
   // reply status codes
   //   ok status: executed, a return outside a handler, or a vector define for 255 (nothing stored)
   //   checksum status: mismatch, nothing done
   //   unknown instruction status: not one of the four
   //   type status: source number out of range, nothing done

   // ==========================================================
   // frame reception
   logic        f_valid;
   logic        f_ok;
   logic [7:0]  f_addr;
   logic [7:0]  f_instr;
   logic [7:0]  f_type;
   logic [31:0] f_value;

   // bank byte unused: the interrupt instructions ignore it
   // fields hold until the next frame's bytes overwrite them
   sid_frame_rx u_rx (
      .clk           (clk),
      .rst           (rst),
      .byte_valid    (byte_valid),
      .byte_data     (byte_data),
      .frame_valid   (f_valid),
      .frame_csum_ok (f_ok),
      .frame_addr    (f_addr),
      .frame_instr   (f_instr),
      .frame_type    (f_type),
      .frame_bank    (),
      .frame_value   (f_value)
   );

   // ==========================================================
   // instruction decode
   // run: main flow, takes allowed at instruction boundaries
   // handler: inside a handler, until the return frame
   // one-hot so a stray code falls to the default branch
   typedef enum logic [1:0] {
      SID_RUN     = 2'b01,
      SID_HANDLER = 2'b10
   } sid_state_e;

   sid_state_e state_q;
   sid_state_e state_d;

   // decode reads only the held frame fields, in the strobe cycle
   // exec needs both the address match and a good checksum
   // frames for another module address are ignored silently
   wire for_us     = f_valid && (f_addr == module_addr);
   wire exec       = for_us && f_ok;
   wire is_global  = (f_type == sid_pkg::IRQ_GLOBAL);
   wire type_ok    = is_global || (32'(f_type) < NUM_IRQ);
   wire op_en      = exec && (f_instr == sid_pkg::OP_IRQ_EN);
   wire op_dis     = exec && (f_instr == sid_pkg::OP_IRQ_DIS);
   wire op_handler_vector_define    = exec && (f_instr == sid_pkg::OP_HANDLER_VECTOR_DEFINE_DEF);
   wire op_ret     = exec && (f_instr == sid_pkg::OP_RETURN);
   wire known_op   = op_en || op_dis || op_handler_vector_define || op_ret;
   wire idx_ok     = type_ok && !is_global;
   wire [$clog2(NUM_IRQ)-1:0] idx = f_type[$clog2(NUM_IRQ)-1:0];

   // a return outside a handler has nothing to restore and is treated as no-op
   // the core then sees no pulse, only an ok reply
   wire do_ret     = op_ret && (state_q == SID_HANDLER);

   // ==========================================================
   // enable mask and global switch
   logic [NUM_IRQ-1:0] mask_q;
   logic               gen_q;

   // global switch and per-source enables are separate bits
   // per-source bits survive a global off, so switching back on is cheap
   // number 255 never touches the mask: idx_ok excludes it
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= '0;
         gen_q  <= 1'b0;
      end else begin
         if (op_en && is_global) begin
            gen_q <= 1'b1;
         end
         if (op_dis && is_global) begin
            gen_q <= 1'b0;
         end
         if (op_en && idx_ok) begin
            mask_q[idx] <= 1'b1;
         end
         if (op_dis && idx_ok) begin
            mask_q[idx] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // vector table; a redefinition simply overwrites the entry
   logic [PC_W-1:0]    handler_vector_define_q [0:NUM_IRQ-1];
   logic [NUM_IRQ-1:0] handler_vector_define_set_q;

   // no reset on the table itself: handler_vector_define_set_q marks the valid entries
   // saves a wide reset tree on the address words
   always_ff @(posedge clk) begin
      if (op_handler_vector_define && idx_ok) begin
         handler_vector_define_q[idx] <= f_value[PC_W-1:0];
      end
   end

   // valid bit per entry, cleared only by reset
   always_ff @(posedge clk) begin
      if (rst) begin
         handler_vector_define_set_q <= '0;
      end else if (op_handler_vector_define && idx_ok) begin
         handler_vector_define_set_q[idx] <= 1'b1;
      end
   end

   // ==========================================================
   // interrupt take: lowest pending enabled source with a vector
   logic [NUM_IRQ-1:0] pend_q;
   wire  [NUM_IRQ-1:0] ready_irq = pend_q & mask_q & handler_vector_define_set_q;
   logic [$clog2(NUM_IRQ)-1:0] sel;
   logic                       any;

   // priority pick: scanning downward leaves the lowest ready source
   always_comb begin
      sel = '0;
      any = 1'b0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (ready_irq[i]) begin
            sel = i[$clog2(NUM_IRQ)-1:0];
            any = 1'b1;
         end
      end
   end

   // no nesting: a source is only taken between instructions in the main flow
   // a return in the same cycle wins, so the restore is never overwritten
   wire take = any && gen_q && instr_boundary && (state_q == SID_RUN) && !do_ret;

   // one-hot clear of the source being taken
   wire [NUM_IRQ-1:0] take_clr = take ? (NUM_IRQ'(1) << sel) : '0;

   // pending latch: a new event in the take cycle of another source stays set
   // an event of the taken source itself in that cycle wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~take_clr) | irq_src;
      end
   end

   // ==========================================================
   // context save on take, restore on return
   logic [PC_W-1:0]         sv_pc_q;
   logic [XREG_W-1:0]       sv_accu_q;
   logic [NUM_X*XREG_W-1:0] sv_x_q;
   logic [FLAG_W-1:0]       sv_flags_q;

   // copies change only on take and hold through the whole handler
   // no reset: nothing reads them before the first take
   always_ff @(posedge clk) begin
      if (take) begin
         sv_pc_q    <= cur_pc;
         sv_accu_q  <= cur_accu;
         sv_x_q     <= cur_xregs;
         sv_flags_q <= cur_flags;
      end
   end

   // state: enter handler on take, leave on return
   always_comb begin
      case (state_q)
         SID_RUN:     state_d = take ? SID_HANDLER : SID_RUN;
         SID_HANDLER: state_d = do_ret ? SID_RUN : SID_HANDLER;
         default:     state_d = SID_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= SID_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // registered outputs toward the interpreter core
   // take and return never coincide: take is gated by !do_ret
   // restore data holds after the pulse, for a core that reads it late
   always_ff @(posedge clk) begin
      if (rst) begin
         pc_load       <= 1'b0;
         pc_load_value <= '0;
         regs_restore  <= 1'b0;
         restore_accu  <= '0;
         restore_xregs <= '0;
         restore_flags <= '0;
      end else begin
         pc_load      <= take || do_ret;
         regs_restore <= do_ret;
         if (take) begin
            pc_load_value <= handler_vector_define_q[sel];
         end
         if (do_ret) begin
            pc_load_value <= sv_pc_q;
            restore_accu  <= sv_accu_q;
            restore_xregs <= sv_x_q;
            restore_flags <= sv_flags_q;
         end
      end
   end

   // ==========================================================
   // direct mode reply; checksum failures get their own status
   // precedence: checksum, then instruction, then source number
   // a return ignores its type byte, so it never gets the type status
   wire [7:0] status_d = !f_ok     ? sid_pkg::STATUS_CSUM   :
                         !known_op ? sid_pkg::STATUS_BADCMD :
                         (!type_ok && !op_ret) ? sid_pkg::STATUS_BADTYP :
                         sid_pkg::STATUS_OK;

   // other addresses neither reply nor update the status
   // standalone mode: effects still happen, only the reply is muted
   always_ff @(posedge clk) begin
      if (rst) begin
         reply_valid  <= 1'b0;
         reply_status <= sid_pkg::BYTE_ZERO;
         reply_instr  <= sid_pkg::BYTE_ZERO;
      end else begin
         reply_valid <= for_us && direct_mode;
         if (for_us) begin
            reply_status <= status_d;
            reply_instr  <= f_instr;
         end
      end
   end

   // outputs from flip-flops
   // one more stage, so mask and global show a cycle after the reply
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask      <= '0;
         irq_global_en <= 1'b0;
         in_handler    <= 1'b0;
      end else begin
         irq_mask      <= mask_q;
         irq_global_en <= gen_q;
         in_handler    <= (state_d == SID_HANDLER);
      end
   end
endmodule : sid_dispatch

/* pkg/sid_pkg.sv */
// constants for the script interrupt dispatch block
package sid_pkg;
   localparam int          FRAME_LEN     = 9;
   localparam int          IDX_ADDR      = 0;
   localparam int          IDX_INSTR     = 1;
   localparam int          IDX_TYPE      = 2;
   localparam int          IDX_BANK      = 3;
   localparam int          IDX_VAL3      = 4;
   localparam int          IDX_CSUM      = 8;
   localparam logic [7:0]  OP_IRQ_EN     = 8'h19;   // 25
   localparam logic [7:0]  OP_IRQ_DIS    = 8'h1a;   // 26
   localparam logic [7:0]  OP_HANDLER_VECTOR_DEFINE_DEF   = 8'h25;   // 37
   localparam logic [7:0]  OP_RETURN     = 8'h26;   // 38
   localparam logic [7:0]  IRQ_GLOBAL    = 8'hff;   // 255
   localparam logic [7:0]  STATUS_OK     = 8'h64;   // 100
   localparam logic [7:0]  STATUS_CSUM   = 8'h01;
   localparam logic [7:0]  STATUS_BADCMD = 8'h02;
   localparam logic [7:0]  STATUS_BADTYP = 8'h03;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   localparam logic [3:0]  CNT_ONE       = 4'h1;
   localparam logic [3:0]  CNT_LAST      = 4'h8;
endpackage : sid_pkg

/* hdl/sid_frame_rx.sv */
// byte assembler and checksum check for one nine-byte command frame
`timescale 1ns/1ps
module sid_frame_rx (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   output logic             frame_valid,
   output logic             frame_csum_ok,
   output logic [7:0]       frame_addr,
   output logic [7:0]       frame_instr,
   output logic [7:0]       frame_type,
   output logic [7:0]       frame_bank,
   output logic [31:0]      frame_value
);
   logic [3:0]  cnt_q;
   logic [7:0]  sum_q;
   logic [7:0]  hdr_q [0:3];
   logic [31:0] val_q;
   wire         last_byte = byte_valid && (cnt_q == sid_pkg::CNT_LAST);

   // byte counter and running sum; the checksum byte is compared not summed
   always_ff @(posedge clk) begin
      if (rst || last_byte) begin
         cnt_q <= sid_pkg::CNT_ZERO;
         sum_q <= sid_pkg::BYTE_ZERO;
      end else if (byte_valid) begin
         cnt_q <= cnt_q + sid_pkg::CNT_ONE;
         sum_q <= sum_q + byte_data;
      end
   end

   // header bytes by position, value shifted in msb first
   always_ff @(posedge clk) begin
      if (byte_valid && cnt_q < 4'(sid_pkg::IDX_VAL3)) begin
         hdr_q[cnt_q[1:0]] <= byte_data;
      end
      if (byte_valid && cnt_q >= 4'(sid_pkg::IDX_VAL3) && !last_byte) begin
         val_q <= {val_q[23:0], byte_data};
      end
   end

   // one-cycle frame strobe with the checksum verdict
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_valid   <= 1'b0;
         frame_csum_ok <= 1'b0;
      end else begin
         frame_valid   <= last_byte;
         frame_csum_ok <= last_byte && (sum_q == byte_data);
      end
   end

   assign frame_addr  = hdr_q[sid_pkg::IDX_ADDR];
   assign frame_instr = hdr_q[sid_pkg::IDX_INSTR];
   assign frame_type  = hdr_q[sid_pkg::IDX_TYPE];
   assign frame_bank  = hdr_q[sid_pkg::IDX_BANK];
   assign frame_value = val_q;
endmodule : sid_frame_rx

/* verification/sid_host_model.sv */
// host model that sends nine-byte command frames
`timescale 1ns/1ps
module sid_host_model (
   input  wire logic  clk,
   output logic       byte_valid,
   output logic [7:0] byte_data
);
   // ==========
   // frame sender
   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
   end
   // idle data is the inverse of the last byte so a stale copy never looks valid
   task automatic send(input logic [7:0] adr, ins, typ, input logic [31:0] val,
                       input logic bad);
      logic [7:0] b [9];
      b = '{adr, ins, typ, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int k = 0; k < 8; k++) b[8] += b[k];
      b[8] ^= {7'h00, bad}; // corrupt only on request
      for (int k = 0; k < 9; k++) begin
         @(posedge clk);
         byte_valid <= 1'b1;
         byte_data  <= b[k];
      end
      @(posedge clk);
      byte_valid <= 1'b0;
      byte_data  <= ~b[8];
   endtask : send
endmodule : sid_host_model

/* verification/sid_dispatch_sva.sv */
// assertion checker for the interrupt dispatch block
`timescale 1ns/1ps
module sid_dispatch_sva #(
   parameter int NUM_IRQ = 16
) (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               direct_mode,
   input wire logic               instr_boundary,
   input wire logic               reply_valid,
   input wire logic [7:0]         reply_status,
   input wire logic [7:0]         reply_instr,
   input wire logic [NUM_IRQ-1:0] irq_mask,
   input wire logic               irq_global_en,
   input wire logic               in_handler,
   input wire logic               pc_load,
   input wire logic               regs_restore
);
   // ==========
   // one clock domain, so one default clock and reset
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_enter;
      in_handler && $past(instr_boundary) && !$past(in_handler);
   endsequence
   sequence s_leave;
      pc_load && !in_handler && $past(in_handler);
   endsequence
   a_reply_pulse: assert property (reply_valid |=> !reply_valid)
      else $error("reply longer than one cycle");
   a_reply_direct: assert property (reply_valid |-> direct_mode)
      else $error("reply outside direct mode");
   a_global_on: assert property ($rose(irq_global_en) |-> $past(reply_valid && reply_status
      == sid_pkg::STATUS_OK && reply_instr == sid_pkg::OP_IRQ_EN))
      else $error("global enable without enable frame");
   a_global_off: assert property (direct_mode && $fell(irq_global_en) |->
      $past(reply_valid && reply_instr == sid_pkg::OP_IRQ_DIS))
      else $error("global disable without disable frame");
   a_mask_cause: assert property (direct_mode && !$stable(irq_mask) |-> $past(reply_valid &&
      reply_status == sid_pkg::STATUS_OK && reply_instr inside {8'h19, 8'h1a}))
      else $error("mask changed without enable or disable");
   a_pc_pulse: assert property (pc_load |=> !pc_load)
      else $error("pc load longer than one cycle");
   a_take_enter: assert property (pc_load && !regs_restore |-> s_enter)
      else $error("vector load without handler entry");
   a_return_leave: assert property (regs_restore |-> s_leave)
      else $error("restore without leaving handler");
   a_handler_exit: assert property ($fell(in_handler) |-> regs_restore)
      else $error("handler left without restore");
endmodule : sid_dispatch_sva
bind sid_dispatch sid_dispatch_sva #(.NUM_IRQ(NUM_IRQ)) u_sva (.clk(clk), .rst(rst),
   .direct_mode(direct_mode), .instr_boundary(instr_boundary), .reply_valid(reply_valid),
   .reply_status(reply_status), .reply_instr(reply_instr), .irq_mask(irq_mask),
   .irq_global_en(irq_global_en), .in_handler(in_handler), .pc_load(pc_load),
   .regs_restore(regs_restore));

/* verification/sid_dispatch_tb.sv */
// self-checking bench for the interrupt dispatch block
`timescale 1ns/1ps
module sid_dispatch_tb;
   // ==========
   // signals and instances
   localparam logic [7:0] EN = sid_pkg::OP_IRQ_EN;
   localparam logic [7:0] OK = sid_pkg::STATUS_OK;
   logic        clk, rst, direct_mode, instr_boundary, byte_valid, reply_valid, irq_global_en;
   logic        in_handler, pc_load, regs_restore;
   logic [7:0]  byte_data, module_addr, reply_status, reply_instr, cur_flags, restore_flags;
   logic [15:0] irq_src, irq_mask;
   logic [31:0] cur_pc, cur_accu, pc_load_value, restore_accu;
   logic [63:0] cur_xregs, restore_xregs;
   int          num_errors, checks_done, cyc;
   sid_host_model host (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));
   sid_dispatch uut (.clk(clk), .rst(rst), .direct_mode(direct_mode), .byte_valid(byte_valid),
      .byte_data(byte_data), .module_addr(module_addr), .irq_src(irq_src), .cur_pc(cur_pc),
      .cur_accu(cur_accu), .cur_xregs(cur_xregs), .cur_flags(cur_flags),
      .instr_boundary(instr_boundary), .reply_valid(reply_valid), .reply_status(reply_status),
      .reply_instr(reply_instr), .irq_mask(irq_mask), .irq_global_en(irq_global_en),
      .in_handler(in_handler), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .regs_restore(regs_restore), .restore_accu(restore_accu), .restore_xregs(restore_xregs),
      .restore_flags(restore_flags));
   // ==========
   // helpers
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results();
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   // frame in direct mode; returns once the mask outputs have settled
   task automatic frame(input logic [7:0] ins, typ, input logic [31:0] val, input logic bad,
                        input logic [7:0] st);
      int n;
      n = 0;
      host.send(8'h01, ins, typ, val, bad);
      do begin
         @(posedge clk);
         #1 n++;
      end while (reply_valid !== 1'b1 && n < 6);
      chk("reply", reply_valid, 1'b1);
      chk("status", reply_status, st);
      chk("instr", reply_instr, ins);
      @(posedge clk);
      #1;
   endtask : frame
   task automatic quiet(input logic [7:0] adr, typ);
      logic [3:0] seen;
      seen = 4'h0;
      host.send(adr, EN, typ, 32'h0, 1'b0);
      repeat (5) begin
         @(posedge clk);
         #1 seen = seen + {3'b000, reply_valid};
      end
      chk("no reply", seen, 4'h0);
   endtask : quiet
   // wait a bounded time for a one-cycle pulse of pc_load or of regs_restore
   task automatic catch(input bit want_restore);
      int   n;
      logic sig;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
         sig = want_restore ? regs_restore : pc_load;
      end while (sig !== 1'b1 && n < 8);
      chk("pulse", sig, 1'b1);
   endtask : catch
   // ==========
   // scenarios
   task automatic t_enable_disable();
      frame(EN, 8'h00, 0, 0, OK);
      frame(EN, 8'h0f, 0, 0, OK);
      chk("mask", irq_mask, 16'h8001);
      frame(EN, 8'hff, 0, 0, OK);
      chk("global on", irq_global_en, 1);
      frame(sid_pkg::OP_IRQ_DIS, 8'h00, 0, 0, OK);
      chk("mask", irq_mask, 16'h8000);
      frame(sid_pkg::OP_IRQ_DIS, 8'hff, 0, 0, OK);
      chk("global off", irq_global_en, 0);
      chk("mask", irq_mask, 16'h8000);
   endtask : t_enable_disable
   task automatic t_refuse();
      frame(EN, 8'h10, 0, 0, sid_pkg::STATUS_BADTYP);
      frame(EN, 8'h01, 0, 1, sid_pkg::STATUS_CSUM);
      frame(8'h30, 8'h01, 0, 0, sid_pkg::STATUS_BADCMD);
      quiet(8'h02, 8'h02);
      chk("mask", irq_mask, 16'h8000);
      direct_mode <= 1'b0;
      quiet(8'h01, 8'h05);
      chk("mask", irq_mask, 16'h8020);
      direct_mode <= 1'b1;
   endtask : t_refuse
   task automatic t_take_return();
      frame(sid_pkg::OP_RETURN, 8'h00, 0, 0, OK);
      chk("no restore", restore_accu, 32'h0);
      frame(sid_pkg::OP_HANDLER_VECTOR_DEFINE_DEF, 8'h03, 32'h32, 0, OK);
      frame(sid_pkg::OP_HANDLER_VECTOR_DEFINE_DEF, 8'h03, 32'h1234, 0, OK);
      frame(EN, 8'h03, 0, 0, OK);
      frame(EN, 8'hff, 0, 0, OK);
      irq_src[3] <= 1'b1;
      @(posedge clk);
      irq_src <= 16'h0;
      repeat (3) @(posedge clk);
      #1 chk("held off", in_handler, 0);
      instr_boundary <= 1'b1;
      catch(1'b0);
      chk("vector", pc_load_value, 32'h1234);
      chk("entered", in_handler, 1);
      {cur_pc, cur_accu, cur_flags} <= '0;
      cur_xregs <= '0;
      host.send(8'h01, sid_pkg::OP_RETURN, 8'h00, 0, 0); // handler ends in a return
      catch(1'b1);
      chk("pc load", pc_load, 1'b1);
      chk("pc", pc_load_value, 32'h0000_0a0b);
      chk("accu", restore_accu, 32'h1357_9bdf);
      chk("xregs", restore_xregs, 64'h0123_4567_89ab_cdef);
      chk("flags", restore_flags, 8'h5a);
      chk("left", in_handler, 0);
   endtask : t_take_return
   // ==========
   // clock, timeout and main sequence
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // cuts a hang short well past the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      {rst, direct_mode, module_addr} = {1'b1, 1'b1, 8'h01};
      {instr_boundary, irq_src, cur_flags} = {1'b0, 16'h0, 8'h5a};
      {cur_pc, cur_accu, cur_xregs} = {32'h0a0b, 32'h1357_9bdf, 64'h0123_4567_89ab_cdef};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset", {irq_mask, irq_global_en, in_handler}, 0);
      t_enable_disable();
      t_refuse();
      t_take_return();
      results();
   end
endmodule : sid_dispatch_tb
